/* File: inc/aph_defs.svh */
// Offsets, field positions, reset values and coded bytes of the APDU/PIN status block
`ifndef APH_DEFS_SVH
`define APH_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define APH_OFS_CTRL     12'h000
`define APH_OFS_PIN_EN   12'h004
`define APH_OFS_QUAL     12'h008
`define APH_OFS_CMD      12'h00C
`define APH_OFS_STATUS   12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define APH_CTRL_MULTI   0
`define APH_CTRL_ACTIVE  1
`define APH_CTRL_SEL_LO  2
`define APH_CTRL_SECOND  5
`define APH_CTRL_UNIV_EN 6
`define APH_QUAL_PRES    16
`define APH_QUAL_IDX_LO  17
`define APH_CMD_BUILD    0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define APH_CTRL_RST     7'h00
`define APH_PIN_EN_RST   24'h00_0000

// ----------------------------------------------------------------
// Data object tags, key references and qualifier codes
// ----------------------------------------------------------------
`define APH_TAG_TEMPLATE 8'hC6
`define APH_TAG_BITMAP   8'h90
`define APH_TAG_KEYREF   8'h83
`define APH_TAG_QUAL     8'h95
`define APH_LEN_ONE      8'h01
`define APH_KREF_PIN     8'h01
`define APH_KREF_SECOND  8'h81
`define APH_KREF_UNIV    8'h11
`define APH_UQ_DO_NOT    8'h00
`define APH_UQ_USER_PIN  8'h08
`define APH_UQ_RFU_MASK  8'hFC

// ----------------------------------------------------------------
// APDU layout
// ----------------------------------------------------------------
`define APH_HDR_LEN      9'd4
`define APH_TMPL_BYTES   20

`endif

/* File: inc/aph_pkg.sv */
// Types shared by the APDU/PIN status block
package aph_pkg;

	// Output sequencer states
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SEND
	} aph_state_e;

	// Structural case of a command
	typedef enum logic [2:0] {
		CASE_NONE,
		CASE_1,
		CASE_2,
		CASE_3,
		CASE_4
	} aph_case_e;

endpackage

/* File: design/aph_qual_mem.sv */
// Per-application usage qualifier store with registered read data
`timescale 1ns/1ps

module aph_qual_mem #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 17,
	parameter int AW    = 3
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] mem_q [DEPTH];   // One word per application
	logic [WIDTH-1:0] rd_data_q;       // Registered read word

	// Array write, no reset needed for contents
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Read data always leaves from a flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= '0;
		end else begin
			rd_data_q <= mem_q[rd_addr];
		end
	end

	assign rd_data = rd_data_q;

endmodule

/* File: design/aph_top.sv */
// APDU case classifier and PIN status template builder with APB registers
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "aph_defs.svh"

module aph_top #(
	parameter int NUM_APPS = 8
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Command APDU byte stream
	input  wire logic        apdu_valid,
	input  wire logic [7:0]  apdu_byte,
	input  wire logic        apdu_last,
	// Case result
	output logic             case_valid,
	output logic [2:0]       case_code,
	output logic             case_malformed,
	output logic [7:0]       hdr_cla,
	output logic [7:0]       hdr_ins,
	output logic [7:0]       hdr_p1,
	output logic [7:0]       hdr_p2,
	// PIN state template byte stream
	output logic             tmpl_valid,
	output logic [7:0]       tmpl_byte,
	output logic             tmpl_last,
	input  wire logic        tmpl_ready
);

	localparam int TB = `APH_TMPL_BYTES;

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_q;   // First stage, read only by the second
	logic rst_n;        // Released copy used everywhere

	// Asynchronous assert, synchronous release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [6:0]          ctrl_q, ctrl_d;         // Mode, active, selection
	logic [23:0]         pin_en_q, pin_en_d;     // Present, second, app enables
	logic [NUM_APPS-1:0] univ_dnu_q, univ_dnu_d; // Per-app universal do-not-use
	logic                kref_err_q, kref_err_d; // Refused build, sticky
	logic [16:0]         qual_rd;                // Qualifier word of selected app
	logic                wr_acc;                 // Write access phase
	logic                qual_wr;                // Qualifier store write
	logic [16:0]         qual_wdata;             // Cleaned qualifier word
	logic                build_req;              // Template build strobe
	logic                sts_clr;                // Status write clears error

	assign wr_acc     = psel && penable && pwrite;
	assign qual_wr    = wr_acc && (paddr == `APH_OFS_QUAL);
	assign build_req  = wr_acc && (paddr == `APH_OFS_CMD) && pwdata[`APH_CMD_BUILD];
	assign sts_clr    = wr_acc && (paddr == `APH_OFS_STATUS);
	// Reserved qualifier bits are forced to zero on every write
	assign qual_wdata = {pwdata[`APH_QUAL_PRES], pwdata[15:8] & `APH_UQ_RFU_MASK,
		pwdata[7:0] & `APH_UQ_RFU_MASK};

	// Register next state
	always_comb begin
		ctrl_d     = ctrl_q;
		pin_en_d   = pin_en_q;
		univ_dnu_d = univ_dnu_q;
		if (wr_acc && paddr == `APH_OFS_CTRL) begin
			ctrl_d = pwdata[6:0];
		end
		if (wr_acc && paddr == `APH_OFS_PIN_EN) begin
			pin_en_d = pwdata[23:0];
		end
		// Universal qualifier tracked per application context
		if (qual_wr) begin
			univ_dnu_d[pwdata[`APH_QUAL_IDX_LO +: 3]] =
				(qual_wdata[15:8] == `APH_UQ_DO_NOT);
		end
	end

	// Register storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q     <= `APH_CTRL_RST;
			pin_en_q   <= `APH_PIN_EN_RST;
			univ_dnu_q <= '0;
			kref_err_q <= 1'b0;
		end else begin
			ctrl_q     <= ctrl_d;
			pin_en_q   <= pin_en_d;
			univ_dnu_q <= univ_dnu_d;
			kref_err_q <= kref_err_d;
		end
	end

	// Qualifier words: {present, universal, application}
	aph_qual_mem #(
		.DEPTH (NUM_APPS),
		.WIDTH (17),
		.AW    (3)
	) u_qual (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (qual_wr),
		.wr_addr (pwdata[`APH_QUAL_IDX_LO +: 3]),
		.wr_data (qual_wdata),
		.rd_addr (ctrl_q[`APH_CTRL_SEL_LO +: 3]),
		.rd_data (qual_rd)
	);

	// ----------------------------------------------------------------
	// Universal qualifier evaluation
	// ----------------------------------------------------------------
	logic [NUM_APPS-1:0] dis_dnu;  // Disabled app that says do-not-use
	logic                all_en;   // Every present app PIN enabled
	logic                def_dnu;  // Default after reset is do-not-use
	logic [7:0]          univ_uq;  // Qualifier used in the template

	genvar gi;
	generate
		for (gi = 0; gi < NUM_APPS; gi++) begin : g_app
			assign dis_dnu[gi] = pin_en_q[16+gi] && !pin_en_q[gi] && univ_dnu_q[gi];
		end
	endgenerate

	assign all_en  = &(pin_en_q[NUM_APPS-1:0] | ~pin_en_q[16 +: NUM_APPS]);
	assign def_dnu = all_en || (|dis_dnu);
	// Idle channel falls back to the reset-time evaluation
	assign univ_uq = !ctrl_q[`APH_CTRL_ACTIVE]
		? (def_dnu ? `APH_UQ_DO_NOT : `APH_UQ_USER_PIN) : qual_rd[15:8];

	// ----------------------------------------------------------------
	// Template assembly
	// ----------------------------------------------------------------
	logic [2:0]        sel;        // Selected application
	logic              multi;      // Multi-verification mode
	logic              with_sec;   // Second secret listed
	logic              with_univ;  // Universal reference listed
	logic [7:0]        kr_pin;     // Application PIN reference
	logic [7:0]        kr_sec;     // Second secret reference
	logic [7:0]        bitmap;     // Enable bitmap byte
	logic [7:0]        tb [TB];    // Assembled bytes
	logic [4:0]        tn;         // Number of bytes used
	logic [8*TB-1:0]   tvec;       // Packed, first byte on top
	logic              sel_bad;    // Selection breaks allocation

	assign sel       = ctrl_q[`APH_CTRL_SEL_LO +: 3];
	assign multi     = ctrl_q[`APH_CTRL_MULTI];
	assign with_sec  = ctrl_q[`APH_CTRL_SECOND];
	assign with_univ = multi;
	// Single mode owns only the first pair of references
	assign kr_pin    = multi ? `APH_KREF_PIN + {5'h00, sel} : `APH_KREF_PIN;
	assign kr_sec    = multi ? `APH_KREF_SECOND + {5'h00, sel} : `APH_KREF_SECOND;
	// One reference pair per application keeps them unshared
	assign sel_bad   = (!multi && sel != 3'd0) || !pin_en_q[16 + 32'(sel)];

	// Byte list with bitmap first and references after it
	always_comb begin
		logic [4:0] k;
		k = 5'd0;
		bitmap = 8'h00;
		for (int i = 0; i < TB; i++) begin
			tb[i] = 8'h00;
		end
		// Bit b8 first, then in reference order
		bitmap[7] = pin_en_q[sel];
		if (with_sec) begin
			bitmap[6] = pin_en_q[8 + 32'(sel)];
		end
		if (with_univ) begin
			bitmap[with_sec ? 5 : 6] = pin_en_q[16 + 32'(sel)];
		end
		tb[0] = `APH_TAG_TEMPLATE;
		tb[2] = `APH_TAG_BITMAP;
		tb[3] = `APH_LEN_ONE;
		tb[4] = bitmap;
		k = 5'd5;
		// Optional application qualifier; absent means always verify
		if (qual_rd[`APH_QUAL_PRES]) begin
			tb[k]      = `APH_TAG_QUAL;
			tb[k+5'd1] = `APH_LEN_ONE;
			tb[k+5'd2] = qual_rd[7:0];
			k = k + 5'd3;
		end
		tb[k]      = `APH_TAG_KEYREF;
		tb[k+5'd1] = `APH_LEN_ONE;
		tb[k+5'd2] = kr_pin;
		k = k + 5'd3;
		if (with_sec) begin
			tb[k]      = `APH_TAG_KEYREF;
			tb[k+5'd1] = `APH_LEN_ONE;
			tb[k+5'd2] = kr_sec;
			k = k + 5'd3;
		end
		// Universal reference always carries its qualifier
		if (with_univ) begin
			tb[k]      = `APH_TAG_QUAL;
			tb[k+5'd1] = `APH_LEN_ONE;
			tb[k+5'd2] = univ_uq;
			tb[k+5'd3] = `APH_TAG_KEYREF;
			tb[k+5'd4] = `APH_LEN_ONE;
			tb[k+5'd5] = `APH_KREF_UNIV;
			k = k + 5'd6;
		end
		tb[1] = {3'b000, k - 5'd2};
		tn = k;
	end

	// Pack so the first byte sits in the top lane
	generate
		for (gi = 0; gi < TB; gi++) begin : g_pack
			assign tvec[8*(TB-gi)-1 -: 8] = tb[gi];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Template output sequencer
	// ----------------------------------------------------------------
	aph_pkg::aph_state_e st_q, st_d;   // Sequencer state
	logic [8*TB-1:0]     shf_q, shf_d; // Bytes still to send
	logic [4:0]          cnt_q, cnt_d; // Bytes left including current

	// Build starts only while idle and the selection is legal
	always_comb begin
		st_d       = st_q;
		shf_d      = shf_q;
		cnt_d      = cnt_q;
		kref_err_d = kref_err_q && !sts_clr;
		unique case (st_q)
			aph_pkg::ST_IDLE: begin
				if (build_req && sel_bad) begin
					kref_err_d = 1'b1;
				end else if (build_req) begin
					st_d  = aph_pkg::ST_SEND;
					shf_d = tvec;
					cnt_d = tn;
				end
			end
			aph_pkg::ST_SEND: begin
				if (tmpl_ready) begin
					shf_d = {shf_q[8*TB-9:0], 8'h00};
					cnt_d = cnt_q - 5'd1;
					if (cnt_q == 5'd1) begin
						st_d = aph_pkg::ST_IDLE;
					end
				end
			end
		endcase
	end

	// Sequencer storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= aph_pkg::ST_IDLE;
			shf_q <= '0;
			cnt_q <= 5'd0;
		end else begin
			st_q  <= st_d;
			shf_q <= shf_d;
			cnt_q <= cnt_d;
		end
	end

	assign tmpl_valid = (st_q == aph_pkg::ST_SEND);
	assign tmpl_byte  = shf_q[8*TB-1 -: 8];
	assign tmpl_last  = tmpl_valid && (cnt_q == 5'd1);

	// ----------------------------------------------------------------
	// Command APDU case classifier
	// ----------------------------------------------------------------
	logic [8:0]  bcnt_q, bcnt_d;     // Bytes seen, saturating
	logic [7:0]  lc_q, lc_d;         // Fifth byte, Lc or Le
	logic [31:0] hdr_q, hdr_d;       // Class, instruction, P1, P2
	logic        cv_q, cv_d;         // Result pulse
	logic [2:0]  cc_q, cc_d;         // Result case
	logic        cm_q, cm_d;         // Result malformed
	logic [8:0]  n;                  // Length including this byte

	assign n = (bcnt_q == 9'h1FF) ? bcnt_q : bcnt_q + 9'd1;

	// Header then optional Lc, data, Le; case from total length
	always_comb begin
		bcnt_d = bcnt_q;
		lc_d   = lc_q;
		hdr_d  = hdr_q;
		cv_d   = 1'b0;
		cc_d   = cc_q;
		cm_d   = cm_q;
		if (apdu_valid) begin
			bcnt_d = apdu_last ? 9'd0 : n;
			if (bcnt_q < `APH_HDR_LEN) begin
				hdr_d[8*(3-32'(bcnt_q[1:0])) +: 8] = apdu_byte;
			end
			if (bcnt_q == `APH_HDR_LEN) begin
				lc_d = apdu_byte;
			end
			if (apdu_last) begin
				cv_d = 1'b1;
				cm_d = 1'b0;
				if (n < `APH_HDR_LEN) begin
					cc_d = aph_pkg::CASE_NONE;
					cm_d = 1'b1;
				end else if (n == `APH_HDR_LEN) begin
					cc_d = aph_pkg::CASE_1;
				end else if (n == `APH_HDR_LEN + 9'd1) begin
					cc_d = aph_pkg::CASE_2;
				end else if (lc_q != 8'h00 && n == `APH_HDR_LEN + 9'd1 + {1'b0, lc_q}) begin
					cc_d = aph_pkg::CASE_3;
				end else if (lc_q != 8'h00 && n == `APH_HDR_LEN + 9'd2 + {1'b0, lc_q}) begin
					cc_d = aph_pkg::CASE_4;
				end else begin
					cc_d = aph_pkg::CASE_NONE;
					cm_d = 1'b1;
				end
			end
		end
	end

	// Classifier storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt_q <= 9'd0;
			lc_q   <= 8'h00;
			hdr_q  <= 32'h0000_0000;
			cv_q   <= 1'b0;
			cc_q   <= 3'd0;
			cm_q   <= 1'b0;
		end else begin
			bcnt_q <= bcnt_d;
			lc_q   <= lc_d;
			hdr_q  <= hdr_d;
			cv_q   <= cv_d;
			cc_q   <= cc_d;
			cm_q   <= cm_d;
		end
	end

	assign case_valid     = cv_q;
	assign case_code      = cc_q;
	assign case_malformed = cm_q;
	assign hdr_cla        = hdr_q[31:24];
	assign hdr_ins        = hdr_q[23:16];
	assign hdr_p1         = hdr_q[15:8];
	assign hdr_p2         = hdr_q[7:0];

	// ----------------------------------------------------------------
	// APB read side
	// ----------------------------------------------------------------
	logic verify_req; // Selected PIN must be presented

	// Missing qualifier means verify whenever enabled
	assign verify_req = pin_en_q[sel] &&
		(!qual_rd[`APH_QUAL_PRES] || qual_rd[3]);

	// Zero-wait slave; unmapped offsets answer an error
	always_comb begin
		prdata  = 32'h0000_0000;
		pready  = 1'b1;
		pslverr = 1'b0;
		unique case (paddr)
			`APH_OFS_CTRL:   prdata = {25'h000_0000, ctrl_q};
			`APH_OFS_PIN_EN: prdata = {8'h00, pin_en_q};
			`APH_OFS_QUAL:   prdata = {15'h0000, qual_rd[16:0]};
			`APH_OFS_CMD:    prdata = 32'h0000_0000;
			`APH_OFS_STATUS: prdata = {16'h0000, univ_uq, verify_req, def_dnu,
				cm_q, cc_q, kref_err_q, tmpl_valid};
			default:         pslverr = psel && penable;
		endcase
	end

endmodule

/* File: test/aph_monitor.sv */
// Concurrent checks on the top ports of the APDU case and PIN template block
`timescale 1ns/1ps
`include "aph_defs.svh"

module aph_monitor (
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// APB slave side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Command byte stream and result
	input wire logic        apdu_valid,
	input wire logic        apdu_last,
	input wire logic        case_valid,
	input wire logic [2:0]  case_code,
	input wire logic        case_malformed,
	// Template stream
	input wire logic        tmpl_valid,
	input wire logic [7:0]  tmpl_byte,
	input wire logic        tmpl_last,
	input wire logic        tmpl_ready
);
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	logic acc;    // Access phase of a transfer
	logic mapped; // Address hits one of the five words
	assign acc    = psel && penable;
	assign mapped = paddr inside {`APH_OFS_CTRL, `APH_OFS_PIN_EN, `APH_OFS_QUAL,
		`APH_OFS_CMD, `APH_OFS_STATUS};

	// One domain, so clock and reset are stated once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	zero_wait_a: assert property (acc |-> pready)
		else $error("pready low in access phase");
	bad_addr_a: assert property (acc && !mapped |-> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	good_addr_a: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access refused");

	// ------------------------------------------------------------
	// Command classification
	// ------------------------------------------------------------
	case_answer_a: assert property (apdu_valid && apdu_last |=> case_valid)
		else $error("no result after last byte");
	case_cause_a: assert property (case_valid |-> $past(apdu_valid && apdu_last))
		else $error("result without last byte");
	case_code_a: assert property (case_valid |->
		case_code <= 3'd4 && (case_malformed == (case_code == 3'd0)))
		else $error("case code and malformed flag disagree");
	case_hold_a: assert property (!case_valid |-> $stable({case_code, case_malformed}))
		else $error("result changed between commands");

	// ------------------------------------------------------------
	// Template stream
	// ------------------------------------------------------------
	tmpl_tag_a: assert property ($rose(tmpl_valid) |-> tmpl_byte == `APH_TAG_TEMPLATE)
		else $error("template does not open with its tag");
	tmpl_hold_a: assert property (tmpl_valid && !tmpl_ready |=>
		tmpl_valid && $stable(tmpl_byte) && $stable(tmpl_last))
		else $error("template byte dropped during stall");
	tmpl_end_a: assert property (tmpl_valid && tmpl_ready && tmpl_last |=> !tmpl_valid)
		else $error("template runs past its last byte");

	// Main scenarios reached
	cover property (case_valid && case_code == 3'd4);
	cover property (tmpl_valid && tmpl_ready && tmpl_last);
	cover property (acc && pslverr);
endmodule

/* File: test/aph_term_model.sv */
// Terminal model: sends command APDUs and takes template bytes with stalls
`timescale 1ns/1ps

module aph_term_model (
	// Clock
	input wire logic  clk,
	// Command byte stream
	output logic       apdu_valid,
	output logic [7:0] apdu_byte,
	output logic       apdu_last,
	// Template sink
	output logic       tmpl_ready
);
	logic [2:0] stall_q = 3'h0; // Stall pattern phase

	// Quiet command lines at time zero; ready has one driver, the stall process
	initial begin
		apdu_valid = 1'b0;
		apdu_byte  = 8'h00;
		apdu_last  = 1'b0;
	end

	// Two stalled cycles in eight, so both prompt and slow acceptance occur
	always @(posedge clk) begin
		stall_q    <= stall_q + 3'd1;
		tmpl_ready <= stall_q != 3'd2 && stall_q != 3'd3;
	end

	// One command, bytes back to back; idle byte lines show the inverse
	task automatic send(input int n, input logic [7:0] lc, input logic [31:0] hdr);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			apdu_valid <= 1'b1;
			apdu_last  <= (i == n - 1);
			apdu_byte  <= (i < 4) ? hdr[31-8*i -: 8] : ((i == 4) ? lc : 8'(i * 37));
		end
		@(posedge clk);
		apdu_valid <= 1'b0;
		apdu_last  <= 1'b0;
		apdu_byte  <= ~apdu_byte;
	endtask
endmodule

/* File: test/tb_apdu_header_and_pin_status.sv */
// Self-checking bench for the APDU case and PIN template block
`timescale 1ns/1ps
`include "aph_defs.svh"

module tb_apdu_header_and_pin_status;
	// Design ports
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        apdu_valid, apdu_last, case_valid, case_malformed;
	logic        tmpl_valid, tmpl_last, tmpl_ready;
	logic [7:0]  apdu_byte, tmpl_byte, hdr_cla, hdr_ins, hdr_p1, hdr_p2;
	logic [2:0]  case_code;
	// Scoreboard queues and counters
	logic [35:0] case_q[$];
	logic [8:0]  tmpl_q[$];
	int          bad_count = 0;
	int          n_checks = 0;
	integer      seed = 92120;
	logic [31:0] rd;
	logic [31:0] h = 32'h0000_0000; // Header the design last holds
	logic        err;

	aph_top #(.NUM_APPS(8)) dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .apdu_valid, .apdu_byte, .apdu_last, .case_valid,
		.case_code, .case_malformed, .hdr_cla, .hdr_ins, .hdr_p1, .hdr_p2, .tmpl_valid,
		.tmpl_byte, .tmpl_last, .tmpl_ready);
	aph_term_model term_u (.clk, .apdu_valid, .apdu_byte, .apdu_last, .tmpl_ready);

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Comparison and reporting
	// ------------------------------------------------------------
	task automatic tally(input logic ok, input logic [35:0] g, input logic [35:0] e);
		n_checks++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		tally(g === e, 36'(g), 36'(e));
	endtask
	task automatic cmp_case(input logic [35:0] g, input logic [35:0] e);
		tally(g === e, g, e);
	endtask
	task automatic cmp_tmpl(input logic [8:0] g, input logic [8:0] e);
		tally(g === e, 36'(g), 36'(e));
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// APB master: hold the request until pready is seen high
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic e_err);
		apb(1'b0, a, '0);
		cmp_reg(rd & m, e);
		cmp_reg(32'(err), 32'(e_err));
	endtask

	// Expected template bytes, last one flagged
	task automatic exp_tmpl(input logic [7:0] bs[]);
		foreach (bs[i]) tmpl_q.push_back({i == bs.size() - 1, bs[i]});
	endtask
	// Bounded wait for every noted result, then anything left is a miss
	task automatic drain;
		for (int i = 0; i < 300 && case_q.size() + tmpl_q.size() != 0; i++) @(posedge clk);
		tally(case_q.size() + tmpl_q.size() == 0, 36'(case_q.size()), '0);
	endtask
	// {malformed, code} from the command length and Lc
	function automatic logic [3:0] exp_case(input int n, input int lc);
		if (n == 4) return 4'h1;
		else if (n == 5) return 4'h2;
		else if (n == 5 + lc) return 4'h3;
		else if (n == 6 + lc) return 4'h4;
		return 4'h8;
	endfunction

	// ------------------------------------------------------------
	// Result watchers: oldest note against each result seen
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (case_valid === 1'b1)
			cmp_case({case_malformed, case_code, hdr_cla, hdr_ins, hdr_p1, hdr_p2},
				case_q.size() ? case_q.pop_front() : '1);
		if (tmpl_valid === 1'b1 && tmpl_ready === 1'b1)
			cmp_tmpl({tmpl_last, tmpl_byte}, tmpl_q.size() ? tmpl_q.pop_front() : '1);
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = '0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		// Reset values, unmapped word, read-back
		rd_chk(`APH_OFS_CTRL, '1, '0, 1'b0);
		rd_chk(`APH_OFS_PIN_EN, '1, '0, 1'b0);
		rd_chk(12'h014, '1, '0, 1'b1);
		apb(1'b1, 12'h014, $random(seed));
		apb(1'b1, `APH_OFS_CTRL, 32'h0000_007F);
		rd_chk(`APH_OFS_CTRL, '1, 32'h0000_007F, 1'b0);
		rd_chk(`APH_OFS_CMD, '1, '0, 1'b0);
		$display("test registers done");
		// Every length around each Lc boundary, random headers
		for (int lc = 1; lc <= 3; lc++) begin
			// Short commands overwrite only the header bytes they carry
			for (int n = (lc == 1) ? 1 : 4; n <= lc + 7; n++) begin
				h = ($random(seed) & ~(32'hFFFF_FFFF >> 8 * n)) | (h & (32'hFFFF_FFFF >> 8 * n));
				case_q.push_back({exp_case(n, lc), h});
				term_u.send(n, 8'(lc), h);
			end
		end
		drain();
		$display("test command cases done");
		// Single verification, second secret listed, app qualifier present
		apb(1'b1, `APH_OFS_CTRL, 32'h0000_0020);
		apb(1'b1, `APH_OFS_PIN_EN, 32'h0001_0001);
		apb(1'b1, `APH_OFS_QUAL, 32'h0001_0008);
		exp_tmpl('{8'hC6, 8'h0C, 8'h90, 8'h01, 8'h80, 8'h95, 8'h01, 8'h08, 8'h83, 8'h01,
			8'h01, 8'h83, 8'h01, 8'h81});
		apb(1'b1, `APH_OFS_CMD, 32'h0000_0001);
		drain();
		// Multi verification, active app 3, reserved qualifier bits written
		apb(1'b1, `APH_OFS_QUAL, 32'h0006_0B00);
		apb(1'b1, `APH_OFS_CTRL, 32'h0000_002F);
		apb(1'b1, `APH_OFS_PIN_EN, 32'h0008_0800);
		exp_tmpl('{8'hC6, 8'h0F, 8'h90, 8'h01, 8'h60, 8'h83, 8'h01, 8'h04, 8'h83, 8'h01,
			8'h84, 8'h95, 8'h01, 8'h08, 8'h83, 8'h01, 8'h11});
		apb(1'b1, `APH_OFS_CMD, 32'h0000_0001);
		drain();
		rd_chk(`APH_OFS_STATUS, 32'h0000_FFC0, 32'h0000_0800, 1'b0);
		// No active app and every PIN enabled: universal do-not-use
		apb(1'b1, `APH_OFS_CTRL, 32'h0000_002D);
		apb(1'b1, `APH_OFS_PIN_EN, 32'h0008_0808);
		exp_tmpl('{8'hC6, 8'h0F, 8'h90, 8'h01, 8'hE0, 8'h83, 8'h01, 8'h04, 8'h83, 8'h01,
			8'h84, 8'h95, 8'h01, 8'h00, 8'h83, 8'h01, 8'h11});
		apb(1'b1, `APH_OFS_CMD, 32'h0000_0001);
		drain();
		rd_chk(`APH_OFS_STATUS, 32'h0000_FFC0, 32'h0000_00C0, 1'b0);
		// Single verification with a second app selected is refused
		apb(1'b1, `APH_OFS_CTRL, 32'h0000_0004);
		apb(1'b1, `APH_OFS_CMD, 32'h0000_0001);
		rd_chk(`APH_OFS_STATUS, 32'h0000_0003, 32'h0000_0002, 1'b0);
		apb(1'b1, `APH_OFS_STATUS, '0);
		rd_chk(`APH_OFS_STATUS, 32'h0000_0002, '0, 1'b0);
		drain();
		$display("test templates done");
		stop_test();
	end
endmodule

bind aph_top aph_monitor mon_u (.clk, .resetn, .psel, .penable, .paddr, .prdata, .pready,
	.pslverr, .apdu_valid, .apdu_last, .case_valid, .case_code, .case_malformed,
	.tmpl_valid, .tmpl_byte, .tmpl_last, .tmpl_ready);
